//--- rtl/fdp_device.sv
// Drive controller end: decodes the command word and reports status
//
// Summary of operation
// - Act on changed bits; stop always evaluated
// - Bits 0-3 jog while held high
// - Bit 4 homing, bit 5 phase current
// - Bit 6 high inhibits all motion
// - Bit 7 runs program; bit 8 rise positions
// - Bits 9-12 drive digital outputs
// - Bit 13 rise clears fault code
// - Bit 14 rise clears alert code
// - Bit 15 rise executes opcode once
// - Bit 16 any change starts positioning
// - Bit 17 selects absolute or relative target
// - Bit 18 polynomial mode; status 4 asks section
// - Master sets bit 19 on last section
// - Bit 20 takes new motion values
// - Master loads opcode, operand, then bit 15
// - Read request returns parameter value
// - Status 0 one; 1,2 with current on
// - Status 3 fault, 7 alert nonzero
// - Status 8 marks command finished
// - Status 9 remote when no program
// - Status 10 stationary at target
// - Status 11-15 limit, home, follow, phases
//
// The AHB-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module fdp_device
  import fdp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  fdp_if.device pd,
  input wire logic limit_hit,
  input wire logic follow_err,
  input wire logic fault_event,
  input wire logic [31:0] fault_value,
  input wire logic alert_event,
  input wire logic [31:0] alert_value,
  output logic [3:0] dig_out,
  output logic [3:0] jog_req,
  output logic motion_enable,
  output logic coil_on,
  output logic move_start,
  output logic move_abs,
  output logic [31:0] move_accel,
  output logic [31:0] move_velo,
  output logic [31:0] move_target
);
  logic [CMD_W-1:0] prev_cmd;
  logic [31:0] fault_code_param;
  logic [31:0] alert_code_param;
  logic [31:0] coil_current_param;
  logic [31:0] program_run_param;
  logic [31:0] pos;
  logic [31:0] goal;
  logic [31:0] result;
  logic [2:0] ramp;
  logic home_found;
  logic command_done;
  logic next_section_request;
  logic poly_active;
  fdp_move_t move;
  fdp_move_t next_move;

  // Edge and level decode of the command word
  wire logic [CMD_W-1:0] cmd = pd.command_bits & ((32'h1 << CB_USED) - 32'h1);
  wire logic [CMD_W-1:0] chg = cmd ^ prev_cmd;
  wire logic [CMD_W-1:0] rise = chg & cmd;
  wire logic stop_lvl = cmd[CB_STOP];
  wire logic pos_go = rise[CB_POS] | chg[CB_POS_TGL];
  wire logic exec_go = rise[CB_EXEC];
  wire logic op_read = pd.opcode[OP_READ_BIT];
  wire logic [15:0] op_num = {1'b0, pd.opcode[14:0]};
  wire logic run_stored_program = cmd[CB_PROG];
  wire logic run_command = exec_go;
  wire logic moving = (move != FDP_IDLE);
  wire logic at_target = (pos == goal);
  // Positions are signed; an unsigned compare would take the long way round
  wire logic [31:0] step = ($signed(goal) > $signed(pos)) ? 32'h1 : 32'hFFFF_FFFF;
  wire logic [31:0] new_goal = cmd[CB_ABS] ? pd.target : pos + pd.target;
  wire logic [3:0] jog_lvl = cmd[CB_JOG_FP:CB_JOG_SN];

  // Parameter read multiplexer
  logic [31:0] rd_val;
  always_comb begin
    unique case (op_num)
      PN_PROGRAM_RUN: rd_val = program_run_param;
      PN_FAULT_CODE: rd_val = fault_code_param;
      PN_ALERT_CODE: rd_val = alert_code_param;
      PN_COIL_CURRENT: rd_val = coil_current_param;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Motion state selection; stop holds everything idle
  always_comb begin
    next_move = move;
    if (stop_lvl) begin
      next_move = FDP_IDLE;
    end else if (pos_go && coil_on) begin
      next_move = FDP_POSITION;
    end else if (run_stored_program && chg[CB_PROG]) begin
      next_move = FDP_PROGRAM;
    end else if (chg[CB_HOME] || (chg[CB_JOG_FP:CB_JOG_SN] != 4'h0)) begin
      if (cmd[CB_HOME]) begin
        next_move = FDP_HOMING;
      end else if (jog_lvl != 4'h0) begin
        next_move = FDP_JOG;
      end else if (move == FDP_JOG || move == FDP_HOMING) begin
        next_move = FDP_IDLE;
      end
    end else if (move == FDP_POSITION && at_target) begin
      next_move = FDP_IDLE;
    end else if (move == FDP_HOMING && pos == 32'h0) begin
      next_move = FDP_IDLE;
    end else if (move == FDP_PROGRAM && !run_stored_program) begin
      next_move = FDP_IDLE;
    end
  end

  // Command history and motion state
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      prev_cmd <= CMD_RST;
      move <= FDP_IDLE;
    end else begin
      prev_cmd <= cmd;
      move <= next_move;
    end
  end

  // Position counter and goal
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pos <= 32'h0;
      goal <= 32'h0;
      ramp <= 3'h0;
    end else begin
      if (pos_go && !stop_lvl && cmd[CB_ACCEPT]) begin
        goal <= new_goal;
      end
      ramp <= moving ? (ramp == 3'(RAMP_CYC) ? ramp : ramp + 3'h1) : 3'h0;
      if (move == FDP_JOG) begin
        pos <= (jog_lvl[0] | jog_lvl[2]) ? pos - 32'h1 : pos + 32'h1;
      end else if (move == FDP_HOMING && pos != 32'h0) begin
        pos <= (pos[31]) ? pos + 32'h1 : pos - 32'h1; // Stop at home, no overshoot
      end else if (move == FDP_POSITION && !at_target) begin
        pos <= pos + step;
      end
    end
  end

  // Parameters, command_done and homing flag
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      fault_code_param <= 32'h0;
      alert_code_param <= 32'h0;
      coil_current_param <= COIL_RST;
      program_run_param <= 32'h0;
      result <= 32'h0;
      command_done <= 1'b0;
      home_found <= 1'b0;
      poly_active <= 1'b0;
      next_section_request <= 1'b0;
    end else begin
      if (fault_event) begin
        fault_code_param <= fault_value; // Set wins over clear
      end else if (rise[CB_CLR_FAULT]) begin
        fault_code_param <= 32'h0;
      end
      if (alert_event) begin
        alert_code_param <= alert_value;
      end else if (rise[CB_CLR_ALERT]) begin
        alert_code_param <= 32'h0;
      end
      if (chg[CB_CURR]) begin
        coil_current_param <= cmd[CB_CURR] ? 32'h1 : 32'h0;
      end
      if (run_command && !op_read && op_num == PN_COIL_CURRENT) begin
        coil_current_param <= pd.operand;
      end
      program_run_param <= {31'h0, move == FDP_PROGRAM};
      if (run_command && op_read) begin
        result <= rd_val;
      end
      command_done <= run_command ? 1'b1 : (chg[CB_EXEC] ? 1'b0 : command_done);
      if (move == FDP_HOMING && next_move == FDP_IDLE && !stop_lvl) begin
        home_found <= 1'b1;
      end else if (next_move == FDP_HOMING) begin
        home_found <= 1'b0;
      end
      poly_active <= cmd[CB_POLY];
      if (cmd[CB_POLY] && !cmd[CB_POLY_LAST]) begin
        next_section_request <= !moving || at_target;
      end else begin
        next_section_request <= 1'b0;
      end
    end
  end

  // Status word assembly
  logic [STS_W-1:0] sts;
  always_comb begin
    sts = 16'h0000;
    sts[SB_ONE] = 1'b1;
    sts[SB_SWON] = coil_current_param != 32'h0;
    sts[SB_OPEN] = coil_current_param != 32'h0;
    sts[SB_FAULT] = fault_code_param != 32'h0;
    sts[SB_NEXT] = next_section_request & poly_active;
    sts[SB_ALERT] = alert_code_param != 32'h0;
    sts[SB_DONE] = command_done;
    sts[SB_REMOTE] = program_run_param == 32'h0;
    sts[SB_TARGET] = !moving && at_target;
    sts[SB_LIMIT] = limit_hit;
    sts[SB_HOME] = home_found;
    sts[SB_FOLLOW] = follow_err;
    sts[SB_ACCEL] = moving && ramp != 3'(RAMP_CYC);
    sts[SB_CONST] = moving && ramp == 3'(RAMP_CYC);
  end

  // Registered outputs
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pd.state_bits <= STS_RST;
      pd.result <= 32'h0;
      pd.act_pos <= 32'h0;
      dig_out <= 4'h0;
      jog_req <= 4'h0;
      motion_enable <= 1'b0;
      coil_on <= 1'b0;
      move_start <= 1'b0;
      move_abs <= 1'b0;
      move_accel <= 32'h0;
      move_velo <= 32'h0;
      move_target <= 32'h0;
    end else begin
      pd.state_bits <= sts;
      pd.result <= result;
      pd.act_pos <= pos;
      dig_out <= cmd[CB_OUT_LO+3:CB_OUT_LO];
      jog_req <= stop_lvl ? 4'h0 : jog_lvl;
      motion_enable <= !stop_lvl;
      coil_on <= coil_current_param != 32'h0;
      move_start <= pos_go && !stop_lvl;
      move_abs <= cmd[CB_ABS];
      if (pos_go && cmd[CB_ACCEPT]) begin
        move_accel <= pd.accel;
        move_velo <= pd.velo;
        move_target <= new_goal;
      end
    end
  end
endmodule : fdp_device
`default_nettype wire

//--- common/fdp_pkg.sv
// Package: process-data layout, control and status bit positions, states
package fdp_pkg;
  localparam int CMD_W = 32;
  localparam int STS_W = 16;
  // Control word bit positions
  localparam int CB_JOG_SN = 0;
  localparam int CB_JOG_SP = 1;
  localparam int CB_JOG_FN = 2;
  localparam int CB_JOG_FP = 3;
  localparam int CB_HOME = 4;
  localparam int CB_CURR = 5;
  localparam int CB_STOP = 6;
  localparam int CB_PROG = 7;
  localparam int CB_POS = 8;
  localparam int CB_OUT_LO = 9;
  localparam int CB_CLR_FAULT = 13;
  localparam int CB_CLR_ALERT = 14;
  localparam int CB_EXEC = 15;
  localparam int CB_POS_TGL = 16;
  localparam int CB_ABS = 17;
  localparam int CB_POLY = 18;
  localparam int CB_POLY_LAST = 19;
  localparam int CB_ACCEPT = 20;
  localparam int CB_USED = 21;
  // Status word bit positions
  localparam int SB_ONE = 0;
  localparam int SB_SWON = 1;
  localparam int SB_OPEN = 2;
  localparam int SB_FAULT = 3;
  localparam int SB_NEXT = 4;
  localparam int SB_ALERT = 7;
  localparam int SB_DONE = 8;
  localparam int SB_REMOTE = 9;
  localparam int SB_TARGET = 10;
  localparam int SB_LIMIT = 11;
  localparam int SB_HOME = 12;
  localparam int SB_FOLLOW = 13;
  localparam int SB_ACCEL = 14;
  localparam int SB_CONST = 15;
  // Parameter numbers carried in the opcode field
  localparam logic [15:0] PN_PROGRAM_RUN = 16'h0000;
  localparam logic [15:0] PN_FAULT_CODE = 16'h000B;
  localparam logic [15:0] PN_ALERT_CODE = 16'h000C;
  localparam logic [15:0] PN_COIL_CURRENT = 16'h0086;
  // Opcode bit 15 marks a read request
  localparam int OP_READ_BIT = 15;
  // Reset values
  localparam logic [CMD_W-1:0] CMD_RST = 32'h0000_0000;
  localparam logic [STS_W-1:0] STS_RST = 16'h0001;
  localparam logic [31:0] COIL_RST = 32'h0000_0000;
  // Moving cycles counted as accelerating phase
  localparam int RAMP_CYC = 4;
  // Bus register offsets (byte addresses)
  localparam logic [7:0] RA_CMD = 8'h00;
  localparam logic [7:0] RA_OPCODE = 8'h04;
  localparam logic [7:0] RA_OPERAND = 8'h08;
  localparam logic [7:0] RA_ACCEL = 8'h0C;
  localparam logic [7:0] RA_VELO = 8'h10;
  localparam logic [7:0] RA_TARGET = 8'h14;
  localparam logic [7:0] RA_STATUS = 8'h18;
  localparam logic [7:0] RA_RESULT = 8'h1C;
  localparam logic [7:0] RA_ACTPOS = 8'h20;
  // Movement states of the device end
  typedef enum logic [2:0] {
    FDP_IDLE = 3'b000,
    FDP_JOG = 3'b001,
    FDP_HOMING = 3'b010,
    FDP_POSITION = 3'b011,
    FDP_PROGRAM = 3'b100
  } fdp_move_t;
endpackage : fdp_pkg

//--- common/fdp_if.sv
// Interface: cyclic process data between master and drive controller
`timescale 1ns/100ps
`default_nettype none
interface fdp_if;
  import fdp_pkg::*;
  logic [CMD_W-1:0] command_bits;
  logic [15:0] opcode;
  logic [31:0] operand;
  logic [31:0] accel;
  logic [31:0] velo;
  logic [31:0] target;
  logic [STS_W-1:0] state_bits;
  logic [31:0] result;
  logic [31:0] act_pos;
  modport device (
    input command_bits, opcode, operand, accel, velo, target,
    output state_bits, result, act_pos
  );
  modport master (
    output command_bits, opcode, operand, accel, velo, target,
    input state_bits, result, act_pos
  );
endinterface : fdp_if
`default_nettype wire

//--- rtl/fdp_master.sv
// Master end: AHB-Lite register slave that drives the process data
`timescale 1ns/100ps
`default_nettype none
module fdp_master
  import fdp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  fdp_if.master pd
);
  logic wr_pend;
  logic [7:0] wr_addr;

  // Address phase decode
  wire logic take = hsel & htrans[1] & hready;
  wire logic [7:0] a = haddr[7:0];
  wire logic known = (a == RA_CMD) | (a == RA_OPCODE) | (a == RA_OPERAND) |
                     (a == RA_ACCEL) | (a == RA_VELO) | (a == RA_TARGET) |
                     (a == RA_STATUS) | (a == RA_RESULT) | (a == RA_ACTPOS);
  wire logic [31:0] rd_mux =
      (a == RA_CMD) ? pd.command_bits :
      (a == RA_OPCODE) ? {16'h0, pd.opcode} :
      (a == RA_OPERAND) ? pd.operand :
      (a == RA_ACCEL) ? pd.accel :
      (a == RA_VELO) ? pd.velo :
      (a == RA_TARGET) ? pd.target :
      (a == RA_STATUS) ? {16'h0, pd.state_bits} :
      (a == RA_RESULT) ? pd.result :
      (a == RA_ACTPOS) ? pd.act_pos : 32'h0;

  // Write pending and read data capture
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h0;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= take & hwrite & known;
      wr_addr <= a;
      if (take && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  // Process-data output fields; parameter set uses opcode+operand then exec
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pd.command_bits <= CMD_RST;
      pd.opcode <= 16'h0;
      pd.operand <= 32'h0;
      pd.accel <= 32'h0;
      pd.velo <= 32'h0;
      pd.target <= 32'h0;
    end else if (wr_pend) begin
      if (wr_addr == RA_CMD) begin
        pd.command_bits <= hwdata;
      end
      if (wr_addr == RA_OPCODE) begin
        pd.opcode <= hwdata[15:0];
      end
      if (wr_addr == RA_OPERAND) begin
        pd.operand <= hwdata;
      end
      if (wr_addr == RA_ACCEL) begin
        pd.accel <= hwdata;
      end
      if (wr_addr == RA_VELO) begin
        pd.velo <= hwdata;
      end
      if (wr_addr == RA_TARGET) begin
        pd.target <= hwdata;
      end
    end
  end
endmodule : fdp_master
`default_nettype wire

//--- test/fdp_assertions.sv
// Checker: relations on the process data between both ends
`timescale 1ns/100ps
`default_nettype none
module fdp_assertions
  import fdp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [CMD_W-1:0] command_bits,
  input wire logic [STS_W-1:0] state_bits
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // Fixed and paired status bits
  a_ready_one: assert property (state_bits[SB_ONE])
    else $error("ready bit low");
  a_unused_zero: assert property (state_bits[6:5] == 2'h0)
    else $error("unused status bits set");
  a_current_pair: assert property (
    state_bits[SB_SWON] == state_bits[SB_OPEN])
    else $error("current status bits differ");
  // Command command_done follows the execute bit
  a_exec_done: assert property (
    $rose(command_bits[CB_EXEC]) |-> ##[1:3] state_bits[SB_DONE])
    else $error("no done after execute");
  a_done_drop: assert property (
    $fell(command_bits[CB_EXEC]) |-> ##[1:3] !state_bits[SB_DONE])
    else $error("done stuck after release");
  // Phase current follows changes of its bit
  a_coil_rise: assert property (
    $rose(command_bits[CB_CURR]) |-> ##[1:3] state_bits[SB_SWON])
    else $error("current not switched on");
  a_coil_fall: assert property (
    $fell(command_bits[CB_CURR]) |-> ##[1:3] !state_bits[SB_SWON])
    else $error("current not switched off");
  // Clear bits remove the active codes
  a_fault_clear: assert property (
    $rose(command_bits[CB_CLR_FAULT]) |-> ##[1:3] !state_bits[SB_FAULT])
    else $error("fault flag not cleared");
  a_alert_clear: assert property (
    $rose(command_bits[CB_CLR_ALERT]) |-> ##[1:3] !state_bits[SB_ALERT])
    else $error("alert flag not cleared");
  // Section request only in open polynomial mode
  a_no_section: assert property (
    (!command_bits[CB_POLY]) [*3] |-> !state_bits[SB_NEXT])
    else $error("section request outside mode");
  a_last_section: assert property (
    command_bits[CB_POLY_LAST] [*3] |-> !state_bits[SB_NEXT])
    else $error("section request after last");
endmodule : fdp_assertions
`default_nettype wire

//--- test/tb_top.sv
// Testbench: master and device ends joined, driven over AHB-Lite
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import fdp_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, m_acc, m_vel, m_tgt, q, c;
  logic hreadyout, hresp, m_en, coil, m_start, m_abs;
  logic [3:0] dig, jog;
  logic lim = 1'b0;
  logic fol = 1'b0;
  logic f_ev = 1'b0;
  logic a_ev = 1'b0;
  logic [31:0] f_val = 32'h0;
  logic [31:0] a_val = 32'h0;
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int starts = 0;
  wire [10:0] outs = {dig, jog, m_en, coil, m_abs};
  fdp_if pd_if ();
  fdp_master fdp_master_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pd(pd_if.master));
  fdp_device fdp_device_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .pd(pd_if.device), .limit_hit(lim), .follow_err(fol),
    .fault_event(f_ev), .fault_value(f_val), .alert_event(a_ev),
    .alert_value(a_val), .dig_out(dig), .jog_req(jog),
    .motion_enable(m_en), .coil_on(coil), .move_start(m_start),
    .move_abs(m_abs), .move_accel(m_acc), .move_velo(m_vel),
    .move_target(m_tgt));
  fdp_assertions fdp_assertions_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .command_bits(pd_if.command_bits), .state_bits(pd_if.state_bits));
  // Clock, cycle ceiling and positioning-start count
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (m_start === 1'b1) starts++;
    if (cycles == 60000) begin
      fail_count++;
      results();
    end
  end
  // Expected status with no motion, codes or command_done
  function automatic logic [15:0] exp_sts(logic [31:0] w, logic l, f);
    exp_sts = 16'h0201;
    exp_sts[SB_SWON] = w[CB_CURR];
    exp_sts[SB_OPEN] = w[CB_CURR];
    exp_sts[SB_LIMIT] = l;
    exp_sts[SB_FOLLOW] = f;
  endfunction : exp_sts
  // Expected level outputs for a command word
  function automatic logic [10:0] exp_out(logic [31:0] w);
    exp_out = {w[12:9], w[CB_STOP] ? 4'h0 : w[3:0], !w[CB_STOP],
      w[CB_CURR], w[CB_ABS]};
  endfunction : exp_out
  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wait_ready();
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
  endtask : wait_ready
  // One single-word transfer; read data lands in q
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    wait_ready();
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic cmd(input logic [31:0] w);
    wr(RA_CMD, w);
    repeat (4) @(posedge clk_sys);
  endtask : cmd
  task automatic st(input int b, input logic e);
    rd(RA_STATUS);
    chk($sformatf("status bit %0d", b), {31'h0, e}, {31'h0, q[b]});
  endtask : st
  task automatic ev(input logic f, a);
    f_ev <= f;
    a_ev <= a;
    @(posedge clk_sys);
    f_ev <= 1'b0;
    a_ev <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : ev
  // Wait for standstill, then check the reached position
  task automatic reach(input logic [31:0] t);
    repeat (4) @(posedge clk_sys);
    while (pd_if.state_bits[SB_TARGET] !== 1'b1) @(posedge clk_sys);
    rd(RA_ACTPOS);
    chk("actual position", t, q);
  endtask : reach
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  // Main sequence
  initial begin
    void'($urandom(32'h1A86));
    repeat (12) @(posedge clk_sys);
    chk("reset status", {16'h0, STS_RST}, {16'h0, pd_if.state_bits});
    chk("reset outputs", 32'h0, {20'h0, outs, m_start});
    rst_b <= 1'b1;
    @(posedge clk_sys);
    rd(8'h40);
    chk("unmapped read", 32'h0, q);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(RA_CMD);
    chk("unmapped write", 32'h0, q);
    for (int i = 0; i < 24; i++) begin
      c = $urandom() & 32'hFFE2_1E6F;
      lim <= 1'($urandom());
      fol <= 1'($urandom());
      cmd(c);
      rd(RA_CMD);
      chk("command", c, q);
      chk("outputs", {21'h0, exp_out(c)}, {21'h0, outs});
      rd(RA_STATUS);
      c[15:0] = exp_sts(c, lim, fol);
      chk("status", {16'h0, c[15:0]}, {16'h0, q[15:0] & 16'h2BFF});
    end
    cmd(32'h0);
    wr(RA_OPCODE, {16'h0, PN_COIL_CURRENT});
    wr(RA_OPERAND, 32'h5);
    cmd(32'h8000);
    st(SB_DONE, 1'b1);
    st(SB_SWON, 1'b1);
    wr(RA_OPCODE, {16'h0, PN_COIL_CURRENT | 16'h8000});
    rd(RA_RESULT);
    chk("result held", 32'h0, q);
    cmd(32'h0);
    st(SB_DONE, 1'b0);
    cmd(32'h8000);
    rd(RA_RESULT);
    chk("coil current", 32'h5, q);
    f_val <= $urandom() | 32'h1;
    a_val <= $urandom() | 32'h1;
    ev(1'b1, 1'b1);
    st(SB_FAULT, 1'b1);
    st(SB_ALERT, 1'b1);
    wr(RA_OPCODE, {16'h0, PN_FAULT_CODE | 16'h8000});
    cmd(32'h0);
    cmd(32'h8000);
    rd(RA_RESULT);
    chk("fault code", f_val, q);
    cmd(32'h2000);
    st(SB_FAULT, 1'b0);
    st(SB_ALERT, 1'b1);
    ev(1'b1, 1'b0);
    st(SB_FAULT, 1'b1);
    cmd(32'h6000);
    st(SB_FAULT, 1'b1);
    st(SB_ALERT, 1'b0);
    wr(RA_ACCEL, 32'h10);
    wr(RA_VELO, 32'h8);
    wr(RA_TARGET, 32'h40);
    cmd(32'h0012_0020);
    starts = 0;
    cmd(32'h0012_0120);
    reach(32'h40);
    chk("move accel", 32'h10, m_acc);
    chk("move velo", 32'h8, m_vel);
    chk("move target", 32'h40, m_tgt);
    wr(RA_TARGET, 32'h20);
    cmd(32'h0013_0120);
    reach(32'h20);
    wr(RA_TARGET, 32'h77);
    cmd(32'h0003_0120);
    cmd(32'h0002_0120);
    reach(32'h20);
    chk("kept target", 32'h20, m_tgt);
    cmd(32'h0002_0160);
    cmd(32'h0003_0160);
    chk("start count", 32'h3, 32'(starts));
    cmd(32'h0004_0000);
    st(SB_NEXT, 1'b1);
    cmd(32'h000C_0000);
    st(SB_NEXT, 1'b0);
    cmd(32'h0000_0080);
    st(SB_REMOTE, 1'b0);
    st(SB_CONST, 1'b1);
    cmd(32'h0);
    st(SB_REMOTE, 1'b1);
    cmd(32'h0000_0010);
    repeat (40) @(posedge clk_sys);
    st(SB_HOME, 1'b1);
    rd(RA_ACTPOS);
    chk("homed position", 32'h0, q);
    cmd(32'h0);
    results();
  end
endmodule : tb_top
`default_nettype wire
